// ===== core/limit_alarm_consts.vh
// constants for the four-level limit alarm
`ifndef LIMIT_ALARM_CONSTS_VH
`define LIMIT_ALARM_CONSTS_VH
`define WORD_W 16
`define BIN_CONST_MAX 16'hffff
`define BCD_CONST_MAX 16'h9999
`define SEL_BINARY 1'b0
`define SEL_DECIMAL 1'b1
// register offsets
`define ADDR_W 4
`define OFF_CTRL 4'h0
`define OFF_TOP 4'h1
`define OFF_HIGH 4'h2
`define OFF_LOW 4'h3
`define OFF_BOTTOM 4'h4
`define OFF_SRC 4'h5
`define OFF_ALARM 4'h6
`define OFF_IRQ_STAT 4'h7
`define OFF_IRQ_MASK 4'h8
// ctrl fields
`define CTRL_SEL_BIT 0
`define CTRL_RESET 16'h0000
`define LIMIT_RESET 16'h0000
`define SRC_RESET 4'h0
`define ALARM_W 4
// alarm bit positions
`define AL_TOP 3
`define AL_HIGH 2
`define AL_LOW 1
`define AL_BOTTOM 0
`endif

// ===== core/threshold_select.v
// picks a threshold from a constant register or a memory word
`timescale 1ns/1ps
`include "limit_alarm_consts.vh"
module threshold_select (
  input wire src_mem,
  input wire decimal_sel,
  input wire [15:0] const_word,
  input wire [15:0] mem_word,
  output wire [15:0] limit
);
  wire [15:0] k_clip;
  assign k_clip = (decimal_sel && const_word > `BCD_CONST_MAX) ? `BCD_CONST_MAX : const_word;
  assign limit = src_mem ? mem_word : k_clip;
endmodule

// ===== core/level_compare.v
// four-level comparison, binary or decimal digits
`timescale 1ns/1ps
`include "limit_alarm_consts.vh"
module level_compare (
  input wire [15:0] value,
  input wire [15:0] top_limit,
  input wire [15:0] high_limit,
  input wire [15:0] low_limit,
  input wire [15:0] bottom_limit,
  output wire [3:0] alarms
);
  // packed digits compare in the same order as their numeric value
  wire top_hit;
  wire bottom_hit;
  assign top_hit = value >= top_limit;
  assign bottom_hit = value <= bottom_limit;
  assign alarms[`AL_TOP] = top_hit;
  assign alarms[`AL_HIGH] = (value >= high_limit) | top_hit;
  assign alarms[`AL_LOW] = (value <= low_limit) | bottom_hit;
  assign alarms[`AL_BOTTOM] = bottom_hit;
endmodule

// ===== core/four_level_limit_alarm.v
// four-level limit alarm with register port and interrupt
//Contract
//- while enabled, each scan updates top, high, low and bottom alarms.
//- binary thresholds are constants 0..65535 or unsigned memory words.
//- top alarm forces high alarm; bottom alarm forces low alarm.
//- low and bottom alarms fire on value less or equal to limit.
//- high and top alarms fire on value greater or equal to limit.
//- a scan with enable low clears all four alarms regardless of value.
//- shared threshold between pair yields one consistent alarm.
//- decimal-digit variant applies same comparison to packed digits.
//- decimal constant thresholds are limited to 0..9999.
`timescale 1ns/1ps
`include "limit_alarm_consts.vh"
module four_level_limit_alarm (
  input wire clk,
  input wire reset_n,
  input wire scan_tick,
  input wire enable,
  input wire [15:0] value,
  input wire [15:0] mem_top,
  input wire [15:0] mem_high,
  input wire [15:0] mem_low,
  input wire [15:0] mem_bottom,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata,
  output reg top_alarm,
  output reg high_alarm,
  output reg low_alarm,
  output reg bottom_alarm,
  output reg irq
);
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [15:0] ctrl_reg;
  reg [15:0] top_reg;
  reg [15:0] high_reg;
  reg [15:0] low_reg;
  reg [15:0] bottom_reg;
  reg [3:0] src_reg;
  reg [3:0] stat_reg;
  reg [3:0] mask_reg;
  reg [3:0] alarm_reg;
  reg [3:0] stat_next;
  reg [3:0] alarm_next;
  wire decimal_sel;
  wire [15:0] lim_top;
  wire [15:0] lim_high;
  wire [15:0] lim_low;
  wire [15:0] lim_bottom;
  wire [3:0] cmp_alarms;
  wire [63:0] const_bus;
  wire [63:0] mem_bus;
  wire [63:0] lim_bus;
  genvar i;
  assign decimal_sel = ctrl_reg[`CTRL_SEL_BIT];
  // ------------------------------------------------------------
  // threshold sources
  // ------------------------------------------------------------
  // one selector per limit, word order follows the alarm bit order
  assign const_bus = {top_reg, high_reg, low_reg, bottom_reg};
  assign mem_bus = {mem_top, mem_high, mem_low, mem_bottom};
  generate
    for (i = 0; i < `ALARM_W; i = i + 1) begin : g_sel
      threshold_select sel (
        .src_mem(src_reg[i]),
        .decimal_sel(decimal_sel),
        .const_word(const_bus[i*`WORD_W +: `WORD_W]),
        .mem_word(mem_bus[i*`WORD_W +: `WORD_W]),
        .limit(lim_bus[i*`WORD_W +: `WORD_W])
      );
    end
  endgenerate
  assign lim_top = lim_bus[`AL_TOP*`WORD_W +: `WORD_W];
  assign lim_high = lim_bus[`AL_HIGH*`WORD_W +: `WORD_W];
  assign lim_low = lim_bus[`AL_LOW*`WORD_W +: `WORD_W];
  assign lim_bottom = lim_bus[`AL_BOTTOM*`WORD_W +: `WORD_W];
  // ------------------------------------------------------------
  // comparison
  // ------------------------------------------------------------
  level_compare cmp (
    .value(value),
    .top_limit(lim_top),
    .high_limit(lim_high),
    .low_limit(lim_low),
    .bottom_limit(lim_bottom),
    .alarms(cmp_alarms)
  );
  // ------------------------------------------------------------
  // alarm update and events
  // ------------------------------------------------------------
  always @* begin
    alarm_next = alarm_reg;
    if (scan_tick) begin
      if (enable) begin
        alarm_next = cmp_alarms;
      end else begin
        alarm_next = {`ALARM_W{1'b0}};
      end
    end
    stat_next = stat_reg;
    if (wr && addr == `OFF_IRQ_STAT) begin
      stat_next = stat_reg & ~wdata[3:0];
    end
    // rising alarms set sticky bits; set wins over clear
    stat_next = stat_next | (alarm_next & ~alarm_reg);
  end
  always @(posedge clk) begin
    if (!reset_n) begin
      alarm_reg <= {`ALARM_W{1'b0}};
      stat_reg <= {`ALARM_W{1'b0}};
      top_alarm <= 1'b0;
      high_alarm <= 1'b0;
      low_alarm <= 1'b0;
      bottom_alarm <= 1'b0;
      irq <= 1'b0;
    end else begin
      alarm_reg <= alarm_next;
      stat_reg <= stat_next;
      top_alarm <= alarm_next[`AL_TOP];
      high_alarm <= alarm_next[`AL_HIGH];
      low_alarm <= alarm_next[`AL_LOW];
      bottom_alarm <= alarm_next[`AL_BOTTOM];
      irq <= |(stat_next & mask_reg);
    end
  end
  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      ctrl_reg <= `CTRL_RESET;
      top_reg <= `LIMIT_RESET;
      high_reg <= `LIMIT_RESET;
      low_reg <= `LIMIT_RESET;
      bottom_reg <= `LIMIT_RESET;
      src_reg <= `SRC_RESET;
      mask_reg <= {`ALARM_W{1'b0}};
    end else if (wr) begin
      if (addr == `OFF_CTRL) begin
        ctrl_reg <= {15'h0000, wdata[`CTRL_SEL_BIT]};
      end else if (addr == `OFF_TOP) begin
        top_reg <= wdata;
      end else if (addr == `OFF_HIGH) begin
        high_reg <= wdata;
      end else if (addr == `OFF_LOW) begin
        low_reg <= wdata;
      end else if (addr == `OFF_BOTTOM) begin
        bottom_reg <= wdata;
      end else if (addr == `OFF_SRC) begin
        src_reg <= wdata[3:0];
      end else if (addr == `OFF_IRQ_MASK) begin
        mask_reg <= wdata[3:0];
      end
    end
  end
  // ------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (!reset_n) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      if (addr == `OFF_CTRL) begin
        rdata <= ctrl_reg;
      end else if (addr == `OFF_TOP) begin
        rdata <= top_reg;
      end else if (addr == `OFF_HIGH) begin
        rdata <= high_reg;
      end else if (addr == `OFF_LOW) begin
        rdata <= low_reg;
      end else if (addr == `OFF_BOTTOM) begin
        rdata <= bottom_reg;
      end else if (addr == `OFF_SRC) begin
        rdata <= {12'h000, src_reg};
      end else if (addr == `OFF_ALARM) begin
        rdata <= {12'h000, alarm_reg};
      end else if (addr == `OFF_IRQ_STAT) begin
        rdata <= {12'h000, stat_reg};
      end else if (addr == `OFF_IRQ_MASK) begin
        rdata <= {12'h000, mask_reg};
      end else begin
        rdata <= 16'h0000;
      end
    end else begin
      rdata <= 16'h0000;
    end
  end
endmodule

// ===== bench/limit_alarm_monitor.sv
// assertion checker bound to the four-level limit alarm top
`timescale 1ns/1ps
`include "limit_alarm_consts.vh"
module limit_alarm_monitor (
  input wire clk,
  input wire reset_n,
  input wire scan_tick,
  input wire enable,
  input wire [15:0] value,
  input wire [3:0] addr,
  input wire rd,
  input wire [15:0] rdata,
  input wire top_alarm,
  input wire high_alarm,
  input wire low_alarm,
  input wire bottom_alarm,
  input wire irq
);
  wire [3:0] al = {top_alarm, high_alarm, low_alarm, bottom_alarm};
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_alarm_hold: assert property (!scan_tick |=> $stable(al)) else $error("alarm moved");
  a_off_clears: assert property (scan_tick && !enable |=> al == 4'h0) else $error("off");
  a_top_high: assert property (top_alarm |-> high_alarm) else $error("top alone");
  a_bottom_low: assert property (bottom_alarm |-> low_alarm) else $error("bottom alone");
  a_zero_low: assert property (scan_tick && enable && value == 16'h0000
    |=> al[1:0] == 2'h3) else $error("zero value");
  a_max_high: assert property (scan_tick && enable && value == 16'hffff
    |=> al[3:2] == 2'h3) else $error("full value");
  a_alarm_read: assert property (rd && addr == `OFF_ALARM && !scan_tick
    |=> rdata == {12'h000, al}) else $error("alarm read");
  a_rdata_idle: assert property (!rd |=> rdata == 16'h0000) else $error("rdata idle");
  c_off: cover property (scan_tick && !enable);
  c_top: cover property (scan_tick && enable && value == 16'hffff);
  c_irq: cover property ($rose(irq));
endmodule
bind four_level_limit_alarm limit_alarm_monitor limit_alarm_monitor_i (.clk(clk),
  .reset_n(reset_n), .scan_tick(scan_tick), .enable(enable), .value(value), .addr(addr),
  .rd(rd), .rdata(rdata), .top_alarm(top_alarm), .high_alarm(high_alarm),
  .low_alarm(low_alarm), .bottom_alarm(bottom_alarm), .irq(irq));

// ===== bench/tb.sv
// self-checking bench for the four-level limit alarm
`timescale 1ns/1ps
`include "limit_alarm_consts.vh"
module tb;
  reg clk = 1'b0, reset_n = 1'b0, scan_tick = 1'b0, enable = 1'b0, wr = 1'b0, rd = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [15:0] value = 16'h0, wdata = 16'h0, mem_top = 16'h0, mem_high = 16'h0;
  reg [15:0] mem_low = 16'h0, mem_bottom = 16'h0;
  wire [15:0] rdata;
  wire top_alarm, high_alarm, low_alarm, bottom_alarm, irq;
  integer mismatches = 0, checks = 0;
  four_level_limit_alarm four_level_limit_alarm_i (.clk(clk), .reset_n(reset_n),
    .scan_tick(scan_tick), .enable(enable), .value(value), .mem_top(mem_top),
    .mem_high(mem_high), .mem_low(mem_low), .mem_bottom(mem_bottom), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .top_alarm(top_alarm),
    .high_alarm(high_alarm), .low_alarm(low_alarm), .bottom_alarm(bottom_alarm), .irq(irq));
  initial begin
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    mismatches = mismatches + 1;
    end_sim;
  end
  task end_sim;
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one register access, write or read
  task bus(input w, input [3:0] a, input [15:0] d);
    @(posedge clk);
    {wr, rd, addr, wdata} <= {w, ~w, a, d};
    @(posedge clk);
    {wr, rd} <= 2'b00;
    #1;
  endtask
  task rchk(input [3:0] a, input [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(rdata, e);
  endtask
  // one scan, then compare irq and the four alarms
  task scan(input en, input [15:0] v, input [4:0] e);
    @(posedge clk);
    {scan_tick, enable, value} <= {1'b1, en, v};
    @(posedge clk);
    {scan_tick, value} <= {1'b0, ~v};
    #1 chk({11'h000, irq, top_alarm, high_alarm, low_alarm, bottom_alarm}, {11'h000, e});
  endtask
  task t_sweep;
    rchk(`OFF_CTRL, 16'h0000);
    bus(1'b1, `OFF_SRC, 16'h000f);
    @(posedge clk);
    {mem_top, mem_high, mem_low, mem_bottom} <= {16'h8000, 16'h8000, 16'h0010, 16'h0010};
    scan(1'b1, 16'h8000, 5'h0c);
    scan(1'b1, 16'h7fff, 5'h00);
    scan(1'b1, 16'h0010, 5'h03);
    scan(1'b0, 16'h0010, 5'h00);
    bus(1'b1, `OFF_CTRL, 16'h0001);
    bus(1'b1, `OFF_SRC, 16'h0007);
    bus(1'b1, `OFF_TOP, 16'hffff);
    scan(1'b1, 16'h9999, 5'h0c);
    scan(1'b1, 16'h9998, 5'h04);
    rchk(`OFF_CTRL, 16'h0001);
    bus(1'b1, `OFF_CTRL, 16'h0000);
    scan(1'b1, 16'h9999, 5'h04);
    scan(1'b1, 16'h0010, 5'h03);
  endtask
  task t_irq;
    rchk(4'hf, 16'h0000);
    bus(1'b1, `OFF_ALARM, 16'hffff);
    rchk(`OFF_ALARM, 16'h0003);
    scan(1'b0, 16'h0000, 5'h00);
    bus(1'b1, `OFF_IRQ_STAT, 16'h000f);
    bus(1'b1, `OFF_IRQ_MASK, 16'h0008);
    scan(1'b1, 16'h0000, 5'h03);
    scan(1'b1, 16'hffff, 5'h1c);
    rchk(`OFF_IRQ_STAT, 16'h000f);
    bus(1'b1, `OFF_IRQ_STAT, 16'h0008);
    chk({15'h0000, irq}, 16'h0000);
    rchk(`OFF_IRQ_STAT, 16'h0007);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_sweep;
    t_irq;
    end_sim;
  end
endmodule
